// ### mdps_top.sv
// apb register bank: dma head and completion pointers, statistics counters, interrupts
// assumes a single pclk domain shared with the dma engine and frame classifier
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mdps_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire mdps_pkg::mdps_done_t [7:0] tx_done,
   input wire mdps_pkg::mdps_done_t [7:0] rx_done,
   input wire logic [7:0] tx_queue_end,
   input wire logic [7:0] rx_queue_end,
   input wire logic [15:0] stat_inc,
   output logic [7:0] tx_dma_start,
   output logic [7:0] rx_dma_start,
   output logic [7:0] rx_dma_enable,
   output logic [7:0][31:0] tx_head_ptr,
   output logic [7:0][31:0] rx_head_ptr,
   output logic [7:0] tx_int,
   output logic [7:0] rx_int,
   output logic statistics_pending_interrupt,
   output logic irq
);
   logic [7:0][31:0] tx_cp;
   logic [7:0][31:0] rx_cp;
   logic [7:0] tx_hdp_wr;
   logic [7:0] rx_hdp_wr;
   logic [7:0] tx_cp_wr;
   logic [7:0] rx_cp_wr;
   logic [7:0] tx_err;
   logic [7:0] rx_err;
   logic [7:0] tx_miss;
   logic [7:0] rx_miss;
   logic [15:0][31:0] stat_cnt;
   logic [15:0] stat_wr_sel;
   mdps_pkg::mdps_stat_wr_t stat_wr;
   mdps_pkg::mdps_stat_wr_t [15:0] cnt_wr;

   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic err_r;
   logic err_nxt;
   logic [31:0] mac_ctrl_r;
   logic [31:0] mac_ctrl_nxt;
   logic [4:0] evt_r;
   logic [4:0] evt_nxt;
   logic [4:0] evt_en_r;
   logic [4:0] evt_en_nxt;
   logic [16:0] chan_en_r;
   logic [16:0] chan_en_nxt;
   logic [5:0] clr_cnt_r;
   logic [5:0] clr_cnt_nxt;
   logic stat_clear;
   logic [4:0] evt_set;
   logic [4:0] evt_clr;
   logic [16:0] chan_stat;
   logic [6:0] region;
   logic [2:0] chan;
   logic [3:0] sidx;
   logic is_stat;
   logic mapped;
   logic setup;
   logic acc_wr;
   logic gig_en;
   logic [31:0] stat_msb;
   logic in_tx_hdp;
   logic in_rx_hdp;
   logic in_tx_cp;
   logic in_rx_cp;
   logic wr_mac_ctrl;
   logic wr_evt_en;
   logic wr_chan_en;
   logic wr_evt_clr;

   assign region = paddr[11:5];
   assign chan = paddr[4:2];
   assign sidx = paddr[5:2];
   assign is_stat = paddr[11:6] == mdps_pkg::REG_STAT_BASE[11:6];
   assign setup = psel && !penable;
   // writes act in the single access cycle; pready is always high
   assign acc_wr = psel && penable && pwrite && !err_r;
   assign pready = 1'b1;
   assign pslverr = psel && penable && err_r;
   assign prdata = rdata_r;
   assign gig_en = mac_ctrl_r[mdps_pkg::GIG_EN_BIT];

   assign in_tx_hdp = region == mdps_pkg::REG_TX_HDP[11:5];
   assign in_rx_hdp = region == mdps_pkg::REG_RX_HDP[11:5];
   assign in_tx_cp = region == mdps_pkg::REG_TX_CP[11:5];
   assign in_rx_cp = region == mdps_pkg::REG_RX_CP[11:5];
   // single-word registers only act on an exact address match
   assign wr_mac_ctrl = acc_wr && paddr == mdps_pkg::REG_MAC_CTRL;
   assign wr_evt_en = acc_wr && paddr == mdps_pkg::REG_EVT_EN;
   assign wr_chan_en = acc_wr && paddr == mdps_pkg::REG_CHAN_EN;
   assign wr_evt_clr = acc_wr && paddr == mdps_pkg::REG_EVT_CLR;

   // ---- address decode and read capture at the setup cycle
   // a counter read is a snapshot of the setup edge; a count in the access cycle is not seen
   always_comb begin
      mapped = 1'b1;
      rdata_nxt = rdata_r;
      unique case (1'b1)
         in_tx_hdp: rdata_nxt = tx_head_ptr[chan];
         in_rx_hdp: rdata_nxt = rx_head_ptr[chan];
         in_tx_cp: rdata_nxt = tx_cp[chan];
         in_rx_cp: rdata_nxt = rx_cp[chan];
         paddr == mdps_pkg::REG_MAC_CTRL: rdata_nxt = mac_ctrl_r;
         paddr == mdps_pkg::REG_EVT_STAT: rdata_nxt = {27'h000_0000, evt_r};
         paddr == mdps_pkg::REG_EVT_CLR: rdata_nxt = 32'h0000_0000;
         paddr == mdps_pkg::REG_EVT_EN: rdata_nxt = {27'h000_0000, evt_en_r};
         paddr == mdps_pkg::REG_CHAN_EN: rdata_nxt = {15'h0000, chan_en_r};
         paddr == mdps_pkg::REG_CHAN_STAT: rdata_nxt = {15'h0000, chan_stat};
         is_stat: rdata_nxt = stat_cnt[sidx];
         default: begin
            mapped = 1'b0;
            rdata_nxt = 32'h0000_0000;
         end
      endcase
      if (!setup) begin
         rdata_nxt = rdata_r;
      end
      err_nxt = err_r;
      if (setup) begin
         // narrow writes to a counter are refused rather than half-applied
         err_nxt = !mapped || (pwrite && is_stat && pstrb != 4'hf);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_r <= 32'h0000_0000;
         err_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         err_r <= err_nxt;
      end
   end

   // ---- write strobes toward channels and counters
   always_comb begin
      tx_hdp_wr = 8'h00;
      rx_hdp_wr = 8'h00;
      tx_cp_wr = 8'h00;
      rx_cp_wr = 8'h00;
      stat_wr_sel = 16'h0000;
      if (acc_wr && in_tx_hdp) begin
         tx_hdp_wr[chan] = 1'b1;
      end
      if (acc_wr && in_rx_hdp) begin
         rx_hdp_wr[chan] = 1'b1;
      end
      if (acc_wr && in_tx_cp) begin
         tx_cp_wr[chan] = 1'b1;
      end
      if (acc_wr && in_rx_cp) begin
         rx_cp_wr[chan] = 1'b1;
      end
      if (acc_wr && is_stat) begin
         stat_wr_sel[sidx] = 1'b1;
      end
      stat_wr.wr = acc_wr && is_stat;
      stat_wr.decr = gig_en;
      stat_wr.data = pwdata;
   end

   // every counter sees the same data and mode; only its own strobe differs
   always_comb begin
      for (int k = 0; k < mdps_pkg::STAT_COUNT; k++) begin
         cnt_wr[k] = stat_wr;
         cnt_wr[k].wr = stat_wr.wr && stat_wr_sel[k];
      end
   end

   // ---- control and events
   always_comb begin
      mac_ctrl_nxt = mac_ctrl_r;
      evt_en_nxt = evt_en_r;
      chan_en_nxt = chan_en_r;
      evt_clr = 5'h00;
      if (wr_mac_ctrl) begin
         mac_ctrl_nxt = pwdata;
      end
      if (wr_evt_en) begin
         evt_en_nxt = pwdata[4:0];
      end
      if (wr_chan_en) begin
         chan_en_nxt = pwdata[16:0];
      end
      if (wr_evt_clr) begin
         evt_clr = pwdata[4:0];
      end
      evt_set = 5'h00;
      evt_set[mdps_pkg::EVT_TX_HDP_ERR] = |tx_err;
      evt_set[mdps_pkg::EVT_RX_HDP_ERR] = |rx_err;
      evt_set[mdps_pkg::EVT_TX_CP_MISS] = |tx_miss;
      evt_set[mdps_pkg::EVT_RX_CP_MISS] = |rx_miss;
      evt_set[mdps_pkg::EVT_STAT_NARROW] = psel && penable && pwrite && err_r && is_stat;
      // an event in the clearing cycle survives
      evt_nxt = (evt_r & ~evt_clr) | evt_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mac_ctrl_r <= mdps_pkg::MAC_CTRL_RST;
         evt_r <= 5'h00;
         evt_en_r <= 5'h00;
         chan_en_r <= 17'h0_0000;
      end else begin
         mac_ctrl_r <= mac_ctrl_nxt;
         evt_r <= evt_nxt;
         evt_en_r <= evt_en_nxt;
         chan_en_r <= chan_en_nxt;
      end
   end

   // ---- post-reset counter clear timer
   always_comb begin
      stat_clear = clr_cnt_r == 6'(mdps_pkg::CLR_CYCLES - 1);
      clr_cnt_nxt = clr_cnt_r;
      // the timer parks at its end value so the clear fires once per reset
      if (clr_cnt_r != 6'(mdps_pkg::CLR_CYCLES)) begin
         clr_cnt_nxt = clr_cnt_r + 6'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clr_cnt_r <= 6'h00;
      end else begin
         clr_cnt_r <= clr_cnt_nxt;
      end
   end

   // ---- channels
   genvar i;
   generate
      for (i = 0; i < mdps_pkg::CHANNELS; i++) begin : g_chan
         mdps_chan u_tx (
            .pclk(pclk),
            .presetn(presetn),
            .hdp_wr(tx_hdp_wr[i]),
            .cp_wr(tx_cp_wr[i]),
            .wdata(pwdata),
            .done(tx_done[i]),
            .queue_end(tx_queue_end[i]),
            .hdp_r(tx_head_ptr[i]),
            .cp_r(tx_cp[i]),
            .go_r(tx_dma_start[i]),
            .int_r(tx_int[i]),
            .hdp_err(tx_err[i]),
            .cp_miss(tx_miss[i])
         );
         mdps_chan u_rx (
            .pclk(pclk),
            .presetn(presetn),
            .hdp_wr(rx_hdp_wr[i]),
            .cp_wr(rx_cp_wr[i]),
            .wdata(pwdata),
            .done(rx_done[i]),
            .queue_end(rx_queue_end[i]),
            .hdp_r(rx_head_ptr[i]),
            .cp_r(rx_cp[i]),
            .go_r(rx_dma_start[i]),
            .int_r(rx_int[i]),
            .hdp_err(rx_err[i]),
            .cp_miss(rx_miss[i])
         );
         // a level from the stored pointer, so it drops by itself at the end of the queue
         assign rx_dma_enable[i] = rx_head_ptr[i] != 32'h0000_0000;
      end
   endgenerate

   // ---- statistics counters
   generate
      for (i = 0; i < mdps_pkg::STAT_COUNT; i++) begin : g_stat
         mdps_stat_cnt u_cnt (
            .pclk(pclk),
            .presetn(presetn),
            .clear(stat_clear),
            .inc(stat_inc[i]),
            .wr(cnt_wr[i]),
            .count_r(stat_cnt[i])
         );
         assign stat_msb[i] = stat_cnt[i][mdps_pkg::THRESH_BIT];
      end
      for (i = mdps_pkg::STAT_COUNT; i < 32; i++) begin : g_pad
         assign stat_msb[i] = 1'b0;
      end
   endgenerate

   // level, not sticky: falls only once every counter is back under half scale
   assign statistics_pending_interrupt = |stat_msb;
   assign chan_stat = {statistics_pending_interrupt, rx_int, tx_int};
   assign irq = |(evt_r & evt_en_r) | |(chan_stat & chan_en_r);
endmodule // mdps_top
`default_nettype wire

// ### mdps_pkg.sv
// constants, field layouts and carrier types for the dma pointer and statistics bank
// assumes an apb master on pclk and a dma engine that reports completions on the same clock
package mdps_pkg;
   localparam int CHANNELS = 8;
   localparam int STAT_COUNT = 16;
   localparam int CLR_CYCLES = 38;
   localparam int EVT_BITS = 5;
   localparam int CHAN_EN_BITS = 17;
   localparam int GIG_EN_BIT = 5;
   localparam int THRESH_BIT = 31;
   // register byte offsets
   localparam logic [11:0] REG_TX_HDP = 12'h000;
   localparam logic [11:0] REG_RX_HDP = 12'h020;
   localparam logic [11:0] REG_TX_CP = 12'h040;
   localparam logic [11:0] REG_RX_CP = 12'h060;
   localparam logic [11:0] REG_MAC_CTRL = 12'h080;
   localparam logic [11:0] REG_EVT_STAT = 12'h084;
   localparam logic [11:0] REG_EVT_CLR = 12'h088;
   localparam logic [11:0] REG_EVT_EN = 12'h08c;
   localparam logic [11:0] REG_CHAN_EN = 12'h090;
   localparam logic [11:0] REG_CHAN_STAT = 12'h094;
   localparam logic [11:0] REG_STAT_BASE = 12'h100;
   // event status bit positions
   localparam int EVT_TX_HDP_ERR = 0;
   localparam int EVT_RX_HDP_ERR = 1;
   localparam int EVT_TX_CP_MISS = 2;
   localparam int EVT_RX_CP_MISS = 3;
   localparam int EVT_STAT_NARROW = 4;
   // reset values
   localparam logic [31:0] MAC_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] PTR_RST = 32'h0000_0000;
   localparam logic [31:0] CNT_RST = 32'h0000_0000;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } mdps_done_t;

   typedef struct packed {
      logic wr;
      logic decr;
      logic [31:0] data;
   } mdps_stat_wr_t;
endpackage

// ### mdps_stat_cnt.sv
// one 32-bit statistics counter with direct or write-to-decrement update
// assumes clear, inc and write all come from logic on pclk
`timescale 1ns/1ps
`default_nettype none
module mdps_stat_cnt (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clear,
   input wire logic inc,
   input wire mdps_pkg::mdps_stat_wr_t wr,
   output logic [31:0] count_r
);
   logic [31:0] count_nxt;
   logic [31:0] sum;

   always_comb begin
      sum = count_r + {31'h0000_0000, inc};
      count_nxt = sum;
      if (clear) begin
         count_nxt = mdps_pkg::CNT_RST;
      end else if (wr.wr && wr.decr) begin
         // an increment landing with the write is folded in before subtracting
         count_nxt = (wr.data > sum) ? 32'h0000_0000 : sum - wr.data;
      end else if (wr.wr) begin
         count_nxt = wr.data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= mdps_pkg::CNT_RST;
      end else begin
         count_r <= count_nxt;
      end
   end
endmodule // mdps_stat_cnt
`default_nettype wire

// ### mdps_chan.sv
// one dma channel: head pointer, completion pointer and channel interrupt
// assumes the dma engine reports each finished descriptor and the end of its queue
`timescale 1ns/1ps
`default_nettype none
module mdps_chan (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hdp_wr,
   input wire logic cp_wr,
   input wire logic [31:0] wdata,
   input wire mdps_pkg::mdps_done_t done,
   input wire logic queue_end,
   output logic [31:0] hdp_r,
   output logic [31:0] cp_r,
   output logic go_r,
   output logic int_r,
   output logic hdp_err,
   output logic cp_miss
);
   logic [31:0] hdp_nxt;
   logic [31:0] cp_nxt;
   logic [31:0] last_r;
   logic [31:0] last_nxt;
   logic go_nxt;
   logic int_nxt;
   logic accept;

   always_comb begin
      // zero is always accepted so software can initialise or tear down a queue
      accept = hdp_wr && (hdp_r == 32'h0000_0000 || queue_end || wdata == 32'h0000_0000);
      hdp_err = hdp_wr && !accept;
      hdp_nxt = hdp_r;
      if (accept) begin
         hdp_nxt = wdata;
      end else if (queue_end) begin
         hdp_nxt = 32'h0000_0000;
      end
      go_nxt = accept && (wdata != 32'h0000_0000);
      last_nxt = done.valid ? done.addr : last_r;
      cp_nxt = cp_wr ? wdata : cp_r;
      cp_miss = cp_wr && int_r && (wdata != last_r);
      int_nxt = int_r;
      if (done.valid) begin
         int_nxt = 1'b1;
      end else if (cp_wr && wdata == last_r) begin
         int_nxt = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hdp_r <= mdps_pkg::PTR_RST;
         cp_r <= mdps_pkg::PTR_RST;
         last_r <= mdps_pkg::PTR_RST;
         go_r <= 1'b0;
         int_r <= 1'b0;
      end else begin
         hdp_r <= hdp_nxt;
         cp_r <= cp_nxt;
         last_r <= last_nxt;
         go_r <= go_nxt;
         int_r <= int_nxt;
      end
   end
endmodule // mdps_chan
`default_nettype wire

// ### mdps_top_sva.sv
// port-level assertions for the dma pointer and statistics bank
// assumes the single pclk domain of mdps_top; bound to it after the module
`timescale 1ns/1ps
`default_nettype none
module mdps_top_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic pslverr,
   input wire mdps_pkg::mdps_done_t [7:0] tx_done,
   input wire logic [7:0] tx_queue_end,
   input wire logic [7:0] tx_dma_start,
   input wire logic [7:0] rx_dma_start,
   input wire logic [7:0] rx_dma_enable,
   input wire logic [7:0][31:0] tx_head_ptr,
   input wire logic [7:0][31:0] rx_head_ptr,
   input wire logic [7:0] tx_int
);
   logic wr;
   assign wr = psel & penable & pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_apb_ready: assert property (psel && penable |-> pready)
      else $error("pready low in access phase");
   a_slverr_phase: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access phase");
   a_narrow_refuse: assert property (wr && paddr[11:8] == 4'h1 && pstrb != 4'hf |-> pslverr)
      else $error("narrow counter write not refused");
   a_tx_start_cause: assert property (tx_dma_start[0] |-> $past(wr && paddr == 12'h000))
      else $error("tx start without head write");
   a_tx_start_load: assert property (wr && paddr == 12'h000 && tx_head_ptr[0] == 32'h0
      && pwdata != 32'h0 |=> tx_dma_start[0] && tx_head_ptr[0] == $past(pwdata))
      else $error("tx head write did not start dma");
   a_hdp_busy_hold: assert property (wr && paddr == 12'h000 && tx_head_ptr[0] != 32'h0
      && pwdata != 32'h0 && !tx_queue_end[0] |=> $stable(tx_head_ptr[0]) && !tx_dma_start[0])
      else $error("busy head pointer overwritten");
   a_rx_enable_lvl: assert property (rx_dma_enable[3] == (rx_head_ptr[3] != 32'h0))
      else $error("rx enable does not follow head pointer");
   a_rx_start_en: assert property (rx_dma_start[3] |-> rx_dma_enable[3])
      else $error("rx start while rx disabled");
   a_int_set: assert property (tx_done[1].valid |=> tx_int[1])
      else $error("completion did not raise tx interrupt");
   a_int_drop_cause: assert property ($fell(tx_int[1]) |-> $past(wr && paddr == 12'h044, 2)
      || $past(wr && paddr == 12'h044))
      else $error("tx interrupt dropped without completion write");
endmodule // mdps_top_sva
bind mdps_top mdps_top_sva mdps_top_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .pready(pready), .pslverr(pslverr), .tx_done(tx_done), .tx_queue_end(tx_queue_end),
   .tx_dma_start(tx_dma_start), .rx_dma_start(rx_dma_start), .rx_dma_enable(rx_dma_enable),
   .tx_head_ptr(tx_head_ptr), .rx_head_ptr(rx_head_ptr), .tx_int(tx_int));
`default_nettype wire

// ### tb_top.sv
// self-checking bench for mdps_top, driven over apb
// assumes the 38-cycle counter clear after reset; apb waits follow pready, bounded
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, spi, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   mdps_pkg::mdps_done_t [7:0] tx_done, rx_done;
   logic [7:0] tx_queue_end, rx_queue_end, tx_dma_start, rx_dma_start, rx_dma_enable;
   logic [7:0] tx_int, rx_int;
   logic [15:0] stat_inc;
   logic [7:0][31:0] tx_head_ptr, rx_head_ptr;
   int failures, comparisons;
   mdps_top mdps_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_done(tx_done), .rx_done(rx_done),
      .tx_queue_end(tx_queue_end), .rx_queue_end(rx_queue_end), .stat_inc(stat_inc),
      .tx_dma_start(tx_dma_start), .rx_dma_start(rx_dma_start), .rx_dma_enable(rx_dma_enable),
      .tx_head_ptr(tx_head_ptr), .rx_head_ptr(rx_head_ptr), .tx_int(tx_int), .rx_int(rx_int),
      .statistics_pending_interrupt(spi), .irq(irq));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic complete_run;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // answer taken at the rising edge with pready high; ends at the next falling edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (pready !== 1'b1) begin
         failures++;
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask
   task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'hf);
      chk(n, e, rd);
   endtask
   task automatic bump(input logic [15:0] v);
      @(posedge pclk);
      stat_inc <= v;
      @(posedge pclk);
      stat_inc <= 16'h0;
      @(negedge pclk);
   endtask
   function automatic logic [11:0] ca(input int i);
      return mdps_pkg::REG_STAT_BASE + 12'(4 * i);
   endfunction
   localparam logic [11:0] EVS = mdps_pkg::REG_EVT_STAT;
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      tx_done = '0;
      rx_done = '0;
      {tx_queue_end, rx_queue_end, stat_inc} = '0;
      failures = 0;
      comparisons = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      // counts landing before the clear pulse must be wiped
      bump(16'hffff);
      for (int i = 0; i < 8; i++) wr(mdps_pkg::REG_TX_HDP + 12'(4 * i), 32'h0);
      for (int i = 0; i < 8; i++) wr(mdps_pkg::REG_RX_HDP + 12'(4 * i), 32'h0);
      repeat (40) @(posedge pclk);
      for (int i = 0; i < 16; i++) rdc("cnt_clear", ca(i), 32'h0);
      wr(ca(0), 32'h7fff_fffe);
      bump(16'h0001);
      rdc("cnt_direct", ca(0), 32'h7fff_ffff);
      chk("pend_low", 32'h0, 32'(spi));
      bump(16'h0001);
      chk("pend_high", 32'h1, 32'(spi));
      wr(mdps_pkg::REG_CHAN_EN, 32'h0001_0000);
      chk("irq_pend", 32'h1, 32'(irq));
      wr(ca(1), 32'h8000_0000);
      wr(mdps_pkg::REG_MAC_CTRL, 32'h0000_0020);
      wr(ca(0), 32'h1);
      rdc("cnt_decr", ca(0), 32'h7fff_ffff);
      chk("pend_stays", 32'h1, 32'(spi));
      wr(ca(1), 32'hffff_ffff);
      rdc("cnt_sat", ca(1), 32'h0);
      chk("pend_gone", 32'h0, 32'(spi));
      chk("irq_gone", 32'h0, 32'(irq));
      wr(mdps_pkg::REG_MAC_CTRL, 32'h0);
      wr(ca(2), 32'hffff_ffff);
      bump(16'h0004);
      rdc("cnt_wrap", ca(2), 32'h0);
      wr(ca(3), 32'h5);
      wr(ca(3), 32'h0);
      rdc("cnt_zero", ca(3), 32'h0);
      apb(1'b1, ca(4), 32'h9, 4'h3);
      chk("narrow_err", 32'h1, 32'(err));
      rdc("narrow_cnt", ca(4), 32'h0);
      rdc("narrow_evt", EVS, 32'h10);
      wr(mdps_pkg::REG_EVT_EN, 32'h10);
      chk("irq_evt", 32'h1, 32'(irq));
      wr(mdps_pkg::REG_EVT_CLR, 32'h10);
      chk("irq_clr", 32'h0, 32'(irq));
      wr(mdps_pkg::REG_TX_HDP, 32'h1000);
      chk("tx_start", 32'h1, 32'(tx_dma_start));
      wr(mdps_pkg::REG_TX_HDP, 32'h2000);
      chk("tx_nostart", 32'h0, 32'(tx_dma_start));
      rdc("tx_hdp_kept", mdps_pkg::REG_TX_HDP, 32'h1000);
      rdc("hdp_evt", EVS, 32'h1);
      @(posedge pclk);
      tx_queue_end <= 8'h01;
      @(posedge pclk);
      tx_queue_end <= 8'h00;
      @(negedge pclk);
      chk("tx_hdp_end", 32'h0, tx_head_ptr[0]);
      wr(mdps_pkg::REG_RX_HDP + 12'hc, 32'h500);
      chk("rx_start", 32'h8, 32'(rx_dma_start));
      chk("rx_enable", 32'h8, 32'(rx_dma_enable));
      chk("rx_hdp", 32'h500, rx_head_ptr[3]);
      @(posedge pclk);
      rx_done[3] <= {1'b1, 32'h500};
      @(posedge pclk);
      rx_done[3] <= '0;
      @(negedge pclk);
      chk("rx_int_set", 32'h8, 32'(rx_int));
      wr(mdps_pkg::REG_RX_CP + 12'hc, 32'h500);
      chk("rx_int_drop", 32'h0, 32'(rx_int));
      @(posedge pclk);
      tx_done[1] <= {1'b1, 32'h40};
      @(posedge pclk);
      tx_done[1] <= '0;
      @(negedge pclk);
      chk("tx_int_set", 32'h2, 32'(tx_int));
      wr(mdps_pkg::REG_TX_CP + 12'h4, 32'h30);
      @(negedge pclk);
      chk("tx_int_kept", 32'h2, 32'(tx_int));
      rdc("cp_evt", EVS, 32'h5);
      wr(mdps_pkg::REG_TX_CP + 12'h4, 32'h40);
      @(negedge pclk);
      chk("tx_int_drop", 32'h0, 32'(tx_int));
      apb(1'b0, 12'hffc, 32'h0, 4'hf);
      chk("unmapped_err", 32'h1, 32'(err));
      chk("unmapped_rd", 32'h0, rd);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
